// File: hdl/tcis_dev_end.sv
/*
 * Device end: two-wire slave with pointer-addressed register file,
 * attention input, open-drain interrupt and software reset.
 * Assumes linkClk oversamples the bus lines and that the touch core
 * drives eventIn in the linkClk domain.
 */
// Contract
// - attention low sets communication enable bit
// - interrupt output is active low open drain
// - address 0x5C or 0x5D by select pin
// - data line in and open drain, clock input
// - master starts transfers and makes the clock
// - start, address, command, data bytes, stop
// - start and stop are data edges, clock high
// - idle bus lines stay released high
// - one bit per clock, stable while high
// - ninth clock carries acknowledge low
// - receiver of each byte drives acknowledge
// - eighth address bit selects read or write
// - watch for start plus own address, acknowledge; acknowledged only while communication enable is set
// - first written byte is stored as pointer
// - first data byte goes to pointed register
// - further data bytes advance the pointer
// - reads start at pointer and advance it
// - master sets pointer before any read
// - master rewrites pointer before read-back
// - masters should use repeated starts
// - software reset aborts and restores registers
// - pointer steps by fixed next-address map
`timescale 1ns/1ps
`include "tcis_params.svh"
module tcis_dev_end (
    tcis_if.dev bus,
    input wire logic linkClk,
    input wire logic rst_n,
    input wire logic address_select_in,
    input wire logic eventIn,
    output logic commEnable,
    output logic wrStrobe,
    output tcis_pkg::tcis_byte_t wrAddr,
    output tcis_pkg::tcis_byte_t wrData
);
    import tcis_pkg::*;
    function automatic tcis_byte_t nextPtr(tcis_byte_t p);
        tcis_byte_t n;
        n = p + 8'h01;
        if (p == `TCIS_REG_FIFO || p == `TCIS_REG_STATUS || p == `TCIS_REG_CFG) begin
            n = `TCIS_REG_FIFO;
        end else if (p >= `TCIS_REG_SENSOR) begin
            n = p;
        end
        return n;
    endfunction

    function automatic tcis_byte_t regInit(int i);
        return (i == int'(`TCIS_CFG_IDX)) ? `TCIS_CFG_RESET : `TCIS_REG_RESET;
    endfunction

    logic [3:0] syncOut;
    logic sclS;
    logic sdaS;
    logic attnS;
    logic selS;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [6:0] ownAddr;
    tcis_byte_t txByte;

    tcis_dev_e st_q, st_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    tcis_byte_t shift_q, shift_d;
    tcis_byte_t ptr_q, ptr_d;
    logic rw_q, rw_d;
    logic cmdNext_q, cmdNext_d;
    logic sdaOe_q, sdaOe_d;
    logic sclP_q, sdaP_q;
    logic irqOe_q;
    logic wrStrobe_q, wrStrobe_d;
    tcis_byte_t wrAddr_q, wrAddr_d;
    tcis_byte_t wrData_q, wrData_d;
    tcis_byte_t regs_q [0:`TCIS_NREG-1];
    tcis_byte_t regs_d [0:`TCIS_NREG-1];

    // pins into the link domain
    tcis_sync #(.W(4), .INIT(4'hF)) pinSync (
        .clk(linkClk),
        .rst_n(rst_n),
        .din({bus.scl, bus.sda, bus.attnN, address_select_in}),
        .dout(syncOut)
    );

    assign sclS = syncOut[3];
    assign sdaS = syncOut[2];
    assign attnS = syncOut[1];
    assign selS = syncOut[0];
    assign sclRise = sclS & ~sclP_q;
    assign sclFall = ~sclS & sclP_q;
    assign startCond = sclS & sclP_q & sdaP_q & ~sdaS;
    assign stopCond = sclS & sclP_q & ~sdaP_q & sdaS;
    assign ownAddr = selS ? `TCIS_ADDR_HI : `TCIS_ADDR_LO;
    assign txByte = (ptr_q <= `TCIS_LAST_REG) ? regs_q[ptr_q[4:0]] : '0;

    // pins only ever pull low
    assign bus.sdaSOut = 1'b0;
    assign bus.sdaSOe = sdaOe_q;
    assign bus.irqOut = 1'b0;
    assign bus.irqOe = irqOe_q;
    assign commEnable = regs_q[`TCIS_CFG_IDX][`TCIS_CFG_DCE];
    assign wrStrobe = wrStrobe_q;
    assign wrAddr = wrAddr_q;
    assign wrData = wrData_q;

    always_comb begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        cmdNext_d = cmdNext_q;
        sdaOe_d = sdaOe_q;
        wrStrobe_d = 1'b0;
        wrAddr_d = wrAddr_q;
        wrData_d = wrData_q;
        regs_d = regs_q;
        if (startCond) begin
            // also serves repeated start
            st_d = ST_ADDR;
            bitCnt_d = '0;
            sdaOe_d = 1'b0;
        end else if (stopCond) begin
            st_d = ST_IDLE;
            sdaOe_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: st_d = ST_IDLE;
                ST_ADDR: begin
                    if (sclRise) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == `TCIS_BYTE_LAST) begin
                        if (shift_q[7:1] == ownAddr && commEnable) begin
                            sdaOe_d = 1'b1;
                            rw_d = shift_q[0];
                            st_d = ST_ACK_ADDR;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (sclFall) begin
                        bitCnt_d = '0;
                        if (rw_q) begin
                            st_d = ST_TX;
                            shift_d = txByte;
                            sdaOe_d = ~txByte[7];
                        end else begin
                            st_d = ST_RX;
                            sdaOe_d = 1'b0;
                            cmdNext_d = 1'b1;
                        end
                    end
                end
                ST_RX: begin
                    if (sclRise) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == `TCIS_BYTE_LAST) begin
                        sdaOe_d = 1'b1;
                        st_d = ST_ACK_RX;
                        if (cmdNext_q) begin
                            ptr_d = shift_q;
                            cmdNext_d = 1'b0;
                        end else begin
                            if (ptr_q <= `TCIS_LAST_REG) begin
                                regs_d[ptr_q[4:0]] = shift_q;
                                wrStrobe_d = 1'b1;
                                wrAddr_d = ptr_q;
                                wrData_d = shift_q;
                            end
                            ptr_d = nextPtr(ptr_q);
                        end
                    end
                end
                ST_ACK_RX: begin
                    if (sclFall) begin
                        sdaOe_d = 1'b0;
                        bitCnt_d = '0;
                        st_d = ST_RX;
                    end
                end
                ST_TX: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == `TCIS_BYTE_LAST) begin
                            sdaOe_d = 1'b0;
                            st_d = ST_MACK;
                            ptr_d = nextPtr(ptr_q);
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sdaOe_d = ~shift_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        shift_d = {7'h00, sdaS};
                    end else if (sclFall) begin
                        if (!shift_q[0]) begin
                            st_d = ST_TX;
                            bitCnt_d = '0;
                            shift_d = txByte;
                            sdaOe_d = ~txByte[7];
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
            endcase
        end
        if (!regs_q[`TCIS_CFG_IDX][`TCIS_CFG_RST_N]) begin
            for (int i = 0; i < `TCIS_NREG; i++) begin
                regs_d[i] = regInit(i);
            end
            st_d = ST_IDLE;
            sdaOe_d = 1'b0;
            ptr_d = '0;
            cmdNext_d = 1'b0;
        end
        if (!attnS) begin
            regs_d[`TCIS_CFG_IDX][`TCIS_CFG_DCE] = 1'b1;
        end
    end

    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            bitCnt_q <= '0;
            shift_q <= '0;
            ptr_q <= '0;
            rw_q <= 1'b0;
            cmdNext_q <= 1'b0;
            sdaOe_q <= 1'b0;
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
            irqOe_q <= 1'b0;
            wrStrobe_q <= 1'b0;
            wrAddr_q <= '0;
            wrData_q <= '0;
            for (int i = 0; i < `TCIS_NREG; i++) begin
                regs_q[i] <= regInit(i);
            end
        end else begin
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            cmdNext_q <= cmdNext_d;
            sdaOe_q <= sdaOe_d;
            sclP_q <= sclS;
            sdaP_q <= sdaS;
            irqOe_q <= eventIn;
            wrStrobe_q <= wrStrobe_d;
            wrAddr_q <= wrAddr_d;
            wrData_q <= wrData_d;
            regs_q <= regs_d;
        end
    end
endmodule

// File: hdl/tcis_host_end.sv
/*
 * Host end: two-wire master that sets the pointer and writes one byte,
 * or sets the pointer and reads one byte over a repeated start.
 * Assumes the slave never stretches the clock.
 */
`timescale 1ns/1ps
`include "tcis_params.svh"
module tcis_host_end (
    tcis_if.host bus,
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic startReq,
    input wire logic isRead,
    input wire logic withData,
    input wire logic attentionReq,
    input wire logic [6:0] devAddr,
    input tcis_pkg::tcis_byte_t regAddr,
    input tcis_pkg::tcis_byte_t wrData,
    output logic busy,
    output logic done,
    output logic ackErr,
    output logic irqSeen,
    output tcis_pkg::tcis_byte_t rdData
);
    import tcis_pkg::*;

    logic [1:0] syncOut;
    logic sdaS;
    logic tick;
    logic adv;
    tcis_step_e nstep;
    tcis_host_e st_q, st_d;
    tcis_step_e step_q, step_d;
    logic [1:0] ph_q, ph_d;
    logic [7:0] div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [8:0] tx_q, tx_d;
    logic [8:0] rx_q, rx_d;
    logic sclOe_q, sclOe_d;
    logic sdaOe_q, sdaOe_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic ackErr_q, ackErr_d;
    tcis_byte_t rdData_q, rdData_d;
    logic rd_q, rd_d;
    logic wd_q, wd_d;
    logic [6:0] dev_q, dev_d;
    tcis_byte_t reg_q, reg_d;
    tcis_byte_t dat_q, dat_d;
    logic attnN_q;
    logic irqSeen_q;

    tcis_sync #(.W(2), .INIT(2'h3)) pinSync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din({bus.sda, bus.irq}),
        .dout(syncOut)
    );

    assign sdaS = syncOut[1];
    assign tick = (div_q == 8'(`TCIS_QTR_CYC - 1));
    assign bus.sclOut = 1'b0;
    assign bus.sdaMOut = 1'b0;
    assign bus.sclOe = sclOe_q;
    assign bus.sdaMOe = sdaOe_q;
    assign bus.attnN = attnN_q;
    assign busy = busy_q;
    assign done = done_q;
    assign ackErr = ackErr_q;
    assign rdData = rdData_q;
    assign irqSeen = irqSeen_q;

    always_comb begin
        st_d = st_q;
        step_d = step_q;
        ph_d = ph_q;
        div_d = div_q;
        bit_d = bit_q;
        tx_d = tx_q;
        rx_d = rx_q;
        sclOe_d = sclOe_q;
        sdaOe_d = sdaOe_q;
        busy_d = busy_q;
        done_d = 1'b0;
        ackErr_d = ackErr_q;
        rdData_d = rdData_q;
        rd_d = rd_q;
        wd_d = wd_q;
        dev_d = dev_q;
        reg_d = reg_q;
        dat_d = dat_q;
        adv = 1'b0;
        nstep = step_q;
        if (st_q != HS_IDLE) begin
            div_d = tick ? 8'h00 : div_q + 8'h01;
            if (tick) begin
                ph_d = ph_q + 2'h1;
            end
        end
        unique case (st_q)
            HS_IDLE: begin
                if (startReq) begin
                    rd_d = isRead;
                    wd_d = withData;
                    dev_d = devAddr;
                    reg_d = regAddr;
                    dat_d = wrData;
                    busy_d = 1'b1;
                    ackErr_d = 1'b0;
                    step_d = SP_START;
                    st_d = HS_START;
                    ph_d = '0;
                    div_d = '0;
                end
            end
            HS_START: begin
                if (tick) begin
                    unique case (ph_q)
                        2'h0: sdaOe_d = 1'b0;
                        2'h1: sclOe_d = 1'b0;
                        2'h2: sdaOe_d = 1'b1;
                        2'h3: begin
                            sclOe_d = 1'b1;
                            adv = 1'b1;
                        end
                    endcase
                end
            end
            HS_BIT: begin
                if (tick) begin
                    unique case (ph_q)
                        2'h0: sdaOe_d = ~tx_q[8];
                        2'h1: sclOe_d = 1'b0;
                        2'h2: rx_d = {rx_q[7:0], sdaS};
                        2'h3: begin
                            sclOe_d = 1'b1;
                            tx_d = {tx_q[7:0], 1'b0};
                            bit_d = bit_q + 4'h1;
                            if (bit_q == `TCIS_BYTE_LAST) begin
                                if (step_q == SP_RDATA) begin
                                    rdData_d = rx_q[8:1];
                                end
                                if (step_q != SP_RDATA && rx_q[0]) begin
                                    ackErr_d = 1'b1;
                                    step_d = SP_STOP;
                                    st_d = HS_STOP;
                                end else begin
                                    adv = 1'b1;
                                end
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                if (tick) begin
                    unique case (ph_q)
                        2'h0: sdaOe_d = 1'b1;
                        2'h1: sclOe_d = 1'b0;
                        2'h2: sdaOe_d = 1'b0;
                        2'h3: begin
                            done_d = 1'b1;
                            busy_d = 1'b0;
                            st_d = HS_IDLE;
                        end
                    endcase
                end
            end
        endcase
        if (adv) begin
            unique case (step_q)
                SP_START: nstep = SP_ADDRW;
                SP_ADDRW: nstep = SP_REG;
                SP_REG: nstep = rd_q ? SP_RESTART : (wd_q ? SP_DATA : SP_STOP);
                SP_DATA: nstep = SP_STOP;
                SP_RESTART: nstep = SP_ADDRR;
                SP_ADDRR: nstep = SP_RDATA;
                SP_RDATA: nstep = SP_STOP;
                SP_STOP: nstep = SP_STOP;
            endcase
            step_d = nstep;
            bit_d = '0;
            st_d = HS_BIT;
            unique case (nstep)
                SP_START, SP_RESTART: st_d = HS_START;
                SP_STOP: st_d = HS_STOP;
                SP_ADDRW: tx_d = {dev_q, 1'b0, 1'b1};
                SP_REG: tx_d = {reg_q, 1'b1};
                SP_DATA: tx_d = {dat_q, 1'b1};
                SP_ADDRR: tx_d = {dev_q, 1'b1, 1'b1};
                SP_RDATA: tx_d = {8'hFF, 1'b1};
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= HS_IDLE;
            step_q <= SP_START;
            ph_q <= '0;
            div_q <= '0;
            bit_q <= '0;
            tx_q <= '0;
            rx_q <= '0;
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            ackErr_q <= 1'b0;
            rdData_q <= '0;
            rd_q <= 1'b0;
            wd_q <= 1'b0;
            dev_q <= '0;
            reg_q <= '0;
            dat_q <= '0;
            attnN_q <= 1'b1;
            irqSeen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            step_q <= step_d;
            ph_q <= ph_d;
            div_q <= div_d;
            bit_q <= bit_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            sclOe_q <= sclOe_d;
            sdaOe_q <= sdaOe_d;
            busy_q <= busy_d;
            done_q <= done_d;
            ackErr_q <= ackErr_d;
            rdData_q <= rdData_d;
            rd_q <= rd_d;
            wd_q <= wd_d;
            dev_q <= dev_d;
            reg_q <= reg_d;
            dat_q <= dat_d;
            attnN_q <= ~attentionReq;
            irqSeen_q <= ~syncOut[0];
        end
    end
endmodule

// File: hdl/tcis_if.sv
/*
 * Two-wire bus between the host end and the device end, plus the
 * attention and interrupt pins. Resolves open-drain levels from enables.
 * Assumes pull-ups on every line: a released line reads high.
 */
`timescale 1ns/1ps
interface tcis_if;
    logic sclOut;
    logic sclOe;
    logic sdaMOut;
    logic sdaMOe;
    logic sdaSOut;
    logic sdaSOe;
    logic irqOut;
    logic irqOe;
    logic attnN;
    logic scl;
    logic sda;
    logic irq;

    assign scl = ~(sclOe & ~sclOut);
    assign sda = ~((sdaMOe & ~sdaMOut) | (sdaSOe & ~sdaSOut));
    assign irq = ~(irqOe & ~irqOut);

    modport dev (input scl, input sda, input attnN,
                 output sdaSOut, output sdaSOe, output irqOut, output irqOe);
    modport host (input sda, input irq,
                  output sclOut, output sclOe, output sdaMOut, output sdaMOe,
                  output attnN);
endinterface

// File: hdl/tcis_params.svh
/*
 * Constants of the touch controller serial port: slave addresses,
 * register map, reset values, field positions and bus timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TCIS_PARAMS_SVH
`define TCIS_PARAMS_SVH

`define TCIS_ADDR_LO 7'h5C
`define TCIS_ADDR_HI 7'h5D
`define TCIS_NREG 21
`define TCIS_LAST_REG 8'h14
`define TCIS_REG_FIFO 8'h00
`define TCIS_REG_STATUS 8'h02
`define TCIS_REG_CFG 8'h13
`define TCIS_REG_SENSOR 8'h14
`define TCIS_CFG_IDX 5'h13
`define TCIS_CFG_DCE 0
`define TCIS_CFG_RST_N 1
`define TCIS_CFG_RESET 8'h02
`define TCIS_REG_RESET 8'h00
`define TCIS_BYTE_LAST 4'h8
`define TCIS_SYS_PERIOD_NS 40
`define TCIS_SCL_PERIOD_NS 10000
`define TCIS_QTR_CYC ((`TCIS_SCL_PERIOD_NS / 4) / `TCIS_SYS_PERIOD_NS)

`endif

// File: hdl/tcis_pkg.sv
/*
 * Types shared by both ends of the touch controller serial port.
 * Assumes nothing of its surroundings.
 */
package tcis_pkg;
    typedef logic [7:0] tcis_byte_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_RX, ST_ACK_RX, ST_TX, ST_MACK
    } tcis_dev_e;
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} tcis_host_e;
    typedef enum logic [2:0] {
        SP_START, SP_ADDRW, SP_REG, SP_DATA, SP_RESTART, SP_ADDRR, SP_RDATA, SP_STOP
    } tcis_step_e;
endpackage

// File: hdl/tcis_sync.sv
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level; no word coherence is given.
 */
`timescale 1ns/1ps
module tcis_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// File: tb/tcis_link_assertions.sv
/*
 * Checker of the two-wire bus between host end and device end.
 * Assumes instantiation beside the bus interface, all signals by name.
 */
`timescale 1ns/1ps
module tcis_link_assertions (
    input wire logic sys_clk,
    input wire logic linkClk,
    input wire logic rst_n,
    input wire logic sclOut,
    input wire logic sdaMOe,
    input wire logic sdaSOut,
    input wire logic sdaSOe,
    input wire logic irqOut,
    input wire logic scl,
    input wire logic sda
);
    logic busFree_q;
    logic busFree_d;
    logic prevScl_q;
    logic prevSda_q;
    // bus free from stop until next start
    always_comb begin
        busFree_d = busFree_q;
        if (scl && prevScl_q && prevSda_q && !sda) begin
            busFree_d = 1'b0;
        end
        if (scl && prevScl_q && !prevSda_q && sda) begin
            busFree_d = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busFree_q <= 1'b1;
            prevScl_q <= 1'b1;
            prevSda_q <= 1'b1;
        end else begin
            busFree_q <= busFree_d;
            prevScl_q <= scl;
            prevSda_q <= sda;
        end
    end
    sequence ackHeld;
        sdaSOe throughout scl [*4];
    endsequence
    sequence stopIdle;
        (scl && sda) [*8];
    endsequence
    chk_dev_sda_od: assert property (@(posedge linkClk) disable iff (!rst_n)
        sdaSOut == 1'b0) else $error("device data drive not open drain");
    chk_irq_od: assert property (@(posedge linkClk) disable iff (!rst_n)
        irqOut == 1'b0) else $error("interrupt drive not open drain");
    chk_scl_master: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sclOut == 1'b0) else $error("clock drive not open drain");
    chk_dev_data_stable: assert property (@(posedge linkClk) disable iff (!rst_n)
        $changed(sdaSOe) |-> !scl) else $error("device data moved while clock high");
    chk_idle_released: assert property (@(posedge sys_clk) disable iff (!rst_n)
        busFree_q |-> !sdaSOe) else $error("device drives a free bus");
    chk_ack_held: assert property (@(posedge linkClk) disable iff (!rst_n)
        $rose(scl) && sdaSOe |-> ackHeld) else $error("device low not held");
    chk_start_form: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sdaMOe) && scl |-> ##[1:200] !scl) else $error("start not followed by clock");
    chk_stop_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(sdaMOe) && scl |=> stopIdle) else $error("bus not idle after stop");
endmodule

// File: tb/touch_ctrl_i2c_slave_port_test.sv
/*
 * Bench joining host end and device end over the bus interface.
 * Assumes a 25 MHz system clock and a 64 ns link clock.
 */
`timescale 1ns/1ps
module touch_ctrl_i2c_slave_port_test;
    import tcis_pkg::*;
    logic sys_clk = 0, linkClk = 0, rst_n = 0, startReq = 0, isRead = 0, withData = 0;
    logic attentionReq = 0, selHi = 0, eventIn = 0;
    logic busy, done, ackErr, irqSeen, commEnable, wrStrobe;
    logic [6:0] devAddr = 7'h00;
    tcis_byte_t regAddr = 8'h00, hostData = 8'h00, stAddr = 8'h00, stData = 8'h00;
    tcis_byte_t rdData, wrAddr, wrData;
    int n_fail = 0, total_checks = 0, cycles = 0, nStore = 0;
    tcis_if tcis_if_i ();
    tcis_host_end tcis_host_end_i (.bus(tcis_if_i), .sys_clk(sys_clk), .rst_n(rst_n),
        .startReq(startReq), .isRead(isRead), .withData(withData),
        .attentionReq(attentionReq), .devAddr(devAddr), .regAddr(regAddr),
        .wrData(hostData), .busy(busy), .done(done), .ackErr(ackErr),
        .irqSeen(irqSeen), .rdData(rdData));
    tcis_dev_end tcis_dev_end_i (.bus(tcis_if_i), .linkClk(linkClk), .rst_n(rst_n),
        .address_select_in(selHi), .eventIn(eventIn), .commEnable(commEnable),
        .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));
    tcis_link_assertions tcis_link_assertions_i (.sys_clk(sys_clk), .linkClk(linkClk),
        .rst_n(rst_n), .sclOut(tcis_if_i.sclOut), .sdaMOe(tcis_if_i.sdaMOe),
        .sdaSOut(tcis_if_i.sdaSOut), .sdaSOe(tcis_if_i.sdaSOe),
        .irqOut(tcis_if_i.irqOut), .scl(tcis_if_i.scl), .sda(tcis_if_i.sda));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        #7;
        forever #32 linkClk = ~linkClk;
    end
    // record every register store
    always @(posedge linkClk) begin
        if (wrStrobe === 1'b1) begin
            stAddr <= wrAddr;
            stData <= wrData;
            nStore <= nStore + 1;
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            $display("CHECK FAILED run length expected below %0d seen %0d", 80000, cycles);
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic rd, input logic wd, input logic [6:0] a,
                        input tcis_byte_t r, input tcis_byte_t d);
        int n;
        @(posedge sys_clk);
        #1;
        isRead = rd;
        withData = wd;
        devAddr = a;
        regAddr = r;
        hostData = d;
        startReq = 1'b1;
        @(posedge sys_clk);
        #1;
        startReq = 1'b0;
        chk("busy", 8'h01, busy);
        n = 0;
        while (done !== 1'b1 && n < 12000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 12000) begin
            $display("CHECK FAILED done expected 1 seen 0");
            n_fail++;
            tally_and_finish();
        end
        chk("busy released", 8'h00, busy);
    endtask
    task automatic attend(input logic hi);
        @(posedge sys_clk);
        #1;
        attentionReq = 1'b1;
        selHi = hi;
        repeat (10) @(posedge sys_clk);
        #1;
        attentionReq = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        xfer(1'b0, 1'b1, 7'h5C, 8'h05, 8'hA5);
        chk("nack disabled", 8'h01, ackErr);
        chk("no store disabled", 8'h00, nStore[7:0]);
        attend(1'b0);
        chk("comm enable", 8'h01, commEnable);
        xfer(1'b0, 1'b1, 7'h5C, 8'h05, 8'hA5);
        chk("write ack", 8'h00, ackErr);
        chk("store count", 8'h01, nStore[7:0]);
        chk("store addr", 8'h05, stAddr);
        chk("store data", 8'hA5, stData);
        xfer(1'b0, 1'b0, 7'h5C, 8'h07, 8'h00);
        chk("pointer only ack", 8'h00, ackErr);
        chk("pointer only no store", 8'h01, nStore[7:0]);
        xfer(1'b0, 1'b0, 7'h5D, 8'h05, 8'h00);
        chk("other addr nack", 8'h01, ackErr);
        xfer(1'b1, 1'b0, 7'h5C, 8'h05, 8'h00);
        chk("read ack", 8'h00, ackErr);
        chk("read data", 8'hA5, rdData);
        xfer(1'b1, 1'b0, 7'h5C, 8'h20, 8'h00);
        chk("unmapped read", 8'h00, rdData);
        @(posedge linkClk);
        #1;
        eventIn = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("irq low", 8'h01, irqSeen);
        @(posedge linkClk);
        #1;
        eventIn = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1;
        chk("irq released", 8'h00, irqSeen);
        xfer(1'b0, 1'b1, 7'h5C, 8'h13, 8'h00);
        chk("soft reset", 8'h00, commEnable);
        attend(1'b1);
        xfer(1'b1, 1'b0, 7'h5D, 8'h05, 8'h00);
        chk("high addr ack", 8'h00, ackErr);
        chk("restored reg", 8'h00, rdData);
        tally_and_finish();
    end
endmodule
